// file: core/pif_regs.svh
// Register offsets, field positions, masks and reset values of the peripheral request flags.
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PIF_ADDR_W          4
`define PIF_OFF_FLAGS_A     4'h0
`define PIF_OFF_FLAGS_B     4'h1
`define PIF_OFF_FLAGS_C     4'h2
`define PIF_OFF_EVT_STATUS  4'h3
`define PIF_OFF_EVT_MASK    4'h4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PIF_A_TIMER1_GATE   7
`define PIF_A_ADC_DONE      6
`define PIF_A_SERIAL_RX     5
`define PIF_A_SERIAL_TX     4
`define PIF_A_SYNC_SERIAL   3
`define PIF_A_CAPTURE1      2
`define PIF_A_TIMER2_MATCH  1
`define PIF_A_TIMER1_OVF    0
`define PIF_B_OSC_FAIL      7
`define PIF_B_COMPARATOR2   6
`define PIF_B_COMPARATOR1   5
`define PIF_B_EEPROM_DONE   4
`define PIF_B_BUS_COLL      3
`define PIF_B_CAPTURE2      0
`define PIF_C_CAPTURE4      5
`define PIF_C_CAPTURE3      4
`define PIF_C_TIMER6_MATCH  3
`define PIF_C_TIMER4_MATCH  1
`define PIF_EVT_NEW_A       0
`define PIF_EVT_NEW_B       1
`define PIF_EVT_NEW_C       2

// ----------------------------------------------------------------------------
// Implemented, writable and level-following masks
// ----------------------------------------------------------------------------
`define PIF_A_IMPL          8'hFF
`define PIF_A_WR            8'hCF
`define PIF_A_LVL           8'h30
`define PIF_B_IMPL          8'hF9
`define PIF_B_WR            8'hF9
`define PIF_B_LVL           8'h00
`define PIF_B_C2_MASK       8'h40
`define PIF_C_IMPL          8'h3A
`define PIF_C_WR            8'h3A
`define PIF_C_LVL           8'h00
`define PIF_EVT_IMPL        8'h07

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PIF_FLAGS_RST       8'h00
`define PIF_EVT_STATUS_RST  8'h00
`define PIF_EVT_MASK_RST    8'h00
`define PIF_RD_DATA_RST     8'h00

`endif

// file: core/pif_pkg.sv
// Types shared by the peripheral request flag logic.
`include "pif_regs.svh"

package pif_pkg;

   typedef logic [7:0]              pif_byte_type;
   typedef logic [`PIF_ADDR_W-1:0]  pif_addr_type;

   typedef enum logic [2:0] {
      PIF_SEL_FLAGS_A,
      PIF_SEL_FLAGS_B,
      PIF_SEL_FLAGS_C,
      PIF_SEL_EVT_STATUS,
      PIF_SEL_EVT_MASK,
      PIF_SEL_NONE
   } pif_sel_type;

endpackage : pif_pkg

// file: core/pif_flag_reg.sv
// One 8-bit request flag register with per-bit implemented, writable and level masks.
`include "pif_regs.svh"

module pif_flag_reg #(
   parameter logic [7:0] IMPL_MASK  = 8'hFF,
   parameter logic [7:0] WR_MASK    = 8'hFF,
   parameter logic [7:0] LEVEL_MASK = 8'h00
) (
   // Clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   // Request sources
   input  wire pif_pkg::pif_byte_type i_src,
   // Software write
   input  wire logic                  i_wr,
   input  wire pif_pkg::pif_byte_type i_wdata,
   // Flag state
   output pif_pkg::pif_byte_type      o_flags,
   output pif_pkg::pif_byte_type      o_new
);
   import pif_pkg::*;

   pif_byte_type flags_q;
   pif_byte_type flags_d;

   // ----------------------------------------------------------------------------
   // Per-bit next state
   // ----------------------------------------------------------------------------
   for (genvar b = 0; b < 8; b++) begin : g_bit
      if (!IMPL_MASK[b]) begin : g_unimpl
         assign flags_d[b] = 1'b0;
      end else if (LEVEL_MASK[b]) begin : g_level
         // Read-only flags mirror the pending state of their source.
         assign flags_d[b] = i_src[b];
      end else if (WR_MASK[b]) begin : g_rw
         // A source event in the cycle of a software clear still sets the flag.
         assign flags_d[b] = i_src[b] | (i_wr ? i_wdata[b] : flags_q[b]);
      end else begin : g_sticky
         assign flags_d[b] = i_src[b] | flags_q[b];
      end
   end

   // ----------------------------------------------------------------------------
   // Flag storage
   // ----------------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         flags_q <= `PIF_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign o_flags = flags_q;
   assign o_new   = flags_d & ~flags_q;

endmodule : pif_flag_reg

// file: core/pif_flags.sv
// Peripheral interrupt request flag registers with register port and event interrupt.
//
// Behaviour
// - A flag is set when its source fires, whatever its enable bit or the global enable.
// - Register A holds timer1 gate, ADC, rx, tx, sync serial, capture1, timer2, timer1 ovf.
// - In register A the serial rx and tx flags are read-only, the other six read/write.
// - The serial rx and tx flags read one while their request is pending and zero otherwise.
// - Register B holds osc fail 7, comparator2 6, comparator1 5, EEPROM 4, collision 3, capture2 0.
// - The comparator2 flag exists only in the larger pin-count variant.
// - Register C holds capture4 5, capture3 4, timer6 match 3 and timer4 match 1.
// - Unimplemented bits read zero and ignore writes.
// - All flags clear to zero on every reset.
// - A pending request raises the peripheral request only with its enable and the peripheral enable both set.
`include "pif_regs.svh"

module pif_flags #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   // Register port
   input  wire pif_pkg::pif_addr_type i_addr,
   input  wire pif_pkg::pif_byte_type i_wr_data,
   input  wire logic                  i_wr_en,
   input  wire logic                  i_rd_en,
   output pif_pkg::pif_byte_type      o_rd_data,
   // Register A sources
   input  wire logic                  i_timer1_gate_evt,
   input  wire logic                  i_adc_done_evt,
   input  wire logic                  i_serial_rx_pending,
   input  wire logic                  i_serial_tx_pending,
   input  wire logic                  i_sync_serial_evt,
   input  wire logic                  i_capture1_evt,
   input  wire logic                  i_timer2_match_evt,
   input  wire logic                  i_timer1_overflow_evt,
   // Register B sources
   input  wire logic                  i_osc_fail_evt,
   input  wire logic                  i_comparator2_evt,
   input  wire logic                  i_comparator1_evt,
   input  wire logic                  i_eeprom_write_done_evt,
   input  wire logic                  i_bus_collision_evt,
   input  wire logic                  i_capture2_evt,
   // Register C sources
   input  wire logic                  i_capture4_evt,
   input  wire logic                  i_capture3_evt,
   input  wire logic                  i_timer6_match_evt,
   input  wire logic                  i_timer4_match_evt,
   // Enables held elsewhere
   input  wire pif_pkg::pif_byte_type i_enable_a,
   input  wire pif_pkg::pif_byte_type i_enable_b,
   input  wire pif_pkg::pif_byte_type i_enable_c,
   input  wire logic                  i_peripheral_irq_enable,
   // Flag state and requests
   output pif_pkg::pif_byte_type      o_flags_a,
   output pif_pkg::pif_byte_type      o_flags_b,
   output pif_pkg::pif_byte_type      o_flags_c,
   output logic                       o_periph_irq_req,
   output logic                       o_irq
);
   import pif_pkg::*;

   // ----------------------------------------------------------------------------
   // Register layout
   // ----------------------------------------------------------------------------
   // The small variant has no comparator2 flag at all.
   localparam logic [7:0] B_IMPL = LARGE_VARIANT ? `PIF_B_IMPL
                                                 : (`PIF_B_IMPL & ~`PIF_B_C2_MASK);
   localparam logic [7:0] B_WR   = LARGE_VARIANT ? `PIF_B_WR
                                                 : (`PIF_B_WR & ~`PIF_B_C2_MASK);

   localparam logic [2:0][7:0] IMPL_MASKS = {`PIF_C_IMPL, B_IMPL, `PIF_A_IMPL};
   localparam logic [2:0][7:0] WR_MASKS   = {`PIF_C_WR, B_WR, `PIF_A_WR};
   localparam logic [2:0][7:0] LVL_MASKS  = {`PIF_C_LVL, `PIF_B_LVL, `PIF_A_LVL};

   // ----------------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------------
   logic [2:0][7:0] src;
   logic [2:0][7:0] flags;
   logic [2:0][7:0] new_flags;
   logic [2:0]      flag_wr;
   logic [2:0]      new_evt;
   logic [2:0]      pending;
   logic [2:0][7:0] enables;
   pif_byte_type    src_a;
   pif_byte_type    src_b;
   pif_byte_type    src_c;
   logic            evt_clr_wr;
   logic            evt_mask_wr;
   pif_byte_type    evt_status_q;
   pif_byte_type    evt_status_d;
   pif_byte_type    evt_mask_q;
   pif_byte_type    rd_data_q;
   pif_byte_type    rd_mux;
   pif_sel_type     rd_sel;

   // ----------------------------------------------------------------------------
   // Register A source placement
   // ----------------------------------------------------------------------------
   always_comb begin
      src_a = '0;
      src_a[`PIF_A_TIMER1_GATE]  = i_timer1_gate_evt;
      src_a[`PIF_A_ADC_DONE]     = i_adc_done_evt;
      src_a[`PIF_A_SERIAL_RX]    = i_serial_rx_pending;
      src_a[`PIF_A_SERIAL_TX]    = i_serial_tx_pending;
      src_a[`PIF_A_SYNC_SERIAL]  = i_sync_serial_evt;
      src_a[`PIF_A_CAPTURE1]     = i_capture1_evt;
      src_a[`PIF_A_TIMER2_MATCH] = i_timer2_match_evt;
      src_a[`PIF_A_TIMER1_OVF]   = i_timer1_overflow_evt;
   end

   // ----------------------------------------------------------------------------
   // Register B source placement
   // ----------------------------------------------------------------------------
   always_comb begin
      src_b = '0;
      src_b[`PIF_B_OSC_FAIL]     = i_osc_fail_evt;
      src_b[`PIF_B_COMPARATOR2]  = i_comparator2_evt;
      src_b[`PIF_B_COMPARATOR1]  = i_comparator1_evt;
      src_b[`PIF_B_EEPROM_DONE]  = i_eeprom_write_done_evt;
      src_b[`PIF_B_BUS_COLL]     = i_bus_collision_evt;
      src_b[`PIF_B_CAPTURE2]     = i_capture2_evt;
   end

   // ----------------------------------------------------------------------------
   // Register C source placement
   // ----------------------------------------------------------------------------
   always_comb begin
      src_c = '0;
      src_c[`PIF_C_CAPTURE4]     = i_capture4_evt;
      src_c[`PIF_C_CAPTURE3]     = i_capture3_evt;
      src_c[`PIF_C_TIMER6_MATCH] = i_timer6_match_evt;
      src_c[`PIF_C_TIMER4_MATCH] = i_timer4_match_evt;
   end

   assign src = {src_c, src_b, src_a};

   // ----------------------------------------------------------------------------
   // Flag registers
   // ----------------------------------------------------------------------------
   for (genvar r = 0; r < 3; r++) begin : g_reg
      assign new_evt[r] = |new_flags[r];
      assign pending[r] = |(flags[r] & enables[r]);

      // Each register carries its own implemented, writable and level masks.

      pif_flag_reg #(
         .IMPL_MASK  (IMPL_MASKS[r]),
         .WR_MASK    (WR_MASKS[r]),
         .LEVEL_MASK (LVL_MASKS[r])
      ) u_flag_reg (
         .i_core_clk (i_core_clk),
         .i_rst_n    (i_rst_n),
         .i_src      (src[r]),
         .i_wr       (flag_wr[r]),
         .i_wdata    (i_wr_data),
         .o_flags    (flags[r]),
         .o_new      (new_flags[r])
      );
   end

   assign o_flags_a = flags[0];
   assign o_flags_b = flags[1];
   assign o_flags_c = flags[2];

   // ----------------------------------------------------------------------------
   // Write strobes
   // ----------------------------------------------------------------------------
   // The address decode of the read path also picks the write target.
   always_comb begin
      flag_wr     = 3'b000;
      evt_clr_wr  = 1'b0;
      evt_mask_wr = 1'b0;
      if (i_wr_en) begin
         case (rd_sel)
            PIF_SEL_FLAGS_A: begin
               flag_wr[0] = 1'b1;
            end
            PIF_SEL_FLAGS_B: begin
               flag_wr[1] = 1'b1;
            end
            PIF_SEL_FLAGS_C: begin
               flag_wr[2] = 1'b1;
            end
            PIF_SEL_EVT_STATUS: begin
               evt_clr_wr = 1'b1;
            end
            PIF_SEL_EVT_MASK: begin
               evt_mask_wr = 1'b1;
            end
            default: begin
               flag_wr = 3'b000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Request to the processor
   // ----------------------------------------------------------------------------
   // A request needs its own enable and the peripheral enable together.
   assign enables = {i_enable_c, i_enable_b, i_enable_a};
   assign o_periph_irq_req = i_peripheral_irq_enable && (|pending);

   // ----------------------------------------------------------------------------
   // Event status and mask
   // ----------------------------------------------------------------------------
   always_comb begin
      evt_status_d = evt_status_q;
      if (evt_clr_wr) begin
         evt_status_d = evt_status_q & ~i_wr_data;
      end
      // A new event wins over a clear in the same cycle.
      evt_status_d[`PIF_EVT_NEW_A] = evt_status_d[`PIF_EVT_NEW_A] | new_evt[0];
      evt_status_d[`PIF_EVT_NEW_B] = evt_status_d[`PIF_EVT_NEW_B] | new_evt[1];
      evt_status_d[`PIF_EVT_NEW_C] = evt_status_d[`PIF_EVT_NEW_C] | new_evt[2];
      evt_status_d = evt_status_d & `PIF_EVT_IMPL;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         evt_status_q <= `PIF_EVT_STATUS_RST;
      end else begin
         evt_status_q <= evt_status_d;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         evt_mask_q <= `PIF_EVT_MASK_RST;
      end else if (evt_mask_wr) begin
         evt_mask_q <= i_wr_data & `PIF_EVT_IMPL;
      end
   end

   // The event interrupt is a level that stays high until software clears the status bit or its mask bit.
   assign o_irq = |(evt_status_q & evt_mask_q);

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------
   // One address decode serves the read mux and the write strobes.
   always_comb begin
      case (i_addr)
         `PIF_OFF_FLAGS_A: begin
            rd_sel = PIF_SEL_FLAGS_A;
         end
         `PIF_OFF_FLAGS_B: begin
            rd_sel = PIF_SEL_FLAGS_B;
         end
         `PIF_OFF_FLAGS_C: begin
            rd_sel = PIF_SEL_FLAGS_C;
         end
         `PIF_OFF_EVT_STATUS: begin
            rd_sel = PIF_SEL_EVT_STATUS;
         end
         `PIF_OFF_EVT_MASK: begin
            rd_sel = PIF_SEL_EVT_MASK;
         end
         default: begin
            rd_sel = PIF_SEL_NONE;
         end
      endcase
   end

   always_comb begin
      case (rd_sel)
         PIF_SEL_FLAGS_A: begin
            rd_mux = flags[0];
         end
         PIF_SEL_FLAGS_B: begin
            rd_mux = flags[1] & B_IMPL;
         end
         PIF_SEL_FLAGS_C: begin
            rd_mux = flags[2] & `PIF_C_IMPL;
         end
         PIF_SEL_EVT_STATUS: begin
            rd_mux = evt_status_q;
         end
         PIF_SEL_EVT_MASK: begin
            rd_mux = evt_mask_q;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rd_data_q <= `PIF_RD_DATA_RST;
      end else if (i_rd_en) begin
         rd_data_q <= rd_mux;
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   assign o_rd_data = rd_data_q;

endmodule : pif_flags

// file: test/pif_periph_model.sv
// Stand-in for the on-chip peripherals that feed the request flags.
module pif_periph_model (
   // Clock
   input  wire logic        i_core_clk,
   // Commands from the bench
   input  wire logic [15:0] i_fire,
   input  wire logic [1:0]  i_level,
   // Source lines towards the flag block
   output logic      [15:0] o_evt,
   output logic      [1:0]  o_pending
);
   // Events follow i_fire one cycle late and last only as long as the bench holds it, so the flag block has to latch them itself.
   always @(posedge i_core_clk) begin
      o_evt <= i_fire;
      o_pending <= i_level;
   end
endmodule : pif_periph_model

// file: test/pif_flags_chk.sv
// Concurrent checks on the ports of the request flag block.
module pif_flags_chk (
   // Clock and reset
   input wire logic                  i_core_clk,
   input wire logic                  i_rst_n,
   // Register port
   input wire pif_pkg::pif_addr_type i_addr,
   input wire pif_pkg::pif_byte_type i_wr_data,
   input wire logic                  i_wr_en,
   input wire logic                  i_rd_en,
   input wire pif_pkg::pif_byte_type o_rd_data,
   // Sources and enables
   input wire logic                  i_adc_done_evt,
   input wire logic                  i_serial_rx_pending,
   input wire pif_pkg::pif_byte_type i_enable_a,
   input wire pif_pkg::pif_byte_type i_enable_b,
   input wire pif_pkg::pif_byte_type i_enable_c,
   input wire logic                  i_peripheral_irq_enable,
   // Flags and requests
   input wire pif_pkg::pif_byte_type o_flags_a,
   input wire pif_pkg::pif_byte_type o_flags_b,
   input wire pif_pkg::pif_byte_type o_flags_c,
   input wire logic                  o_periph_irq_req
);
   import pif_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   chk_unimpl_zero: assert property ((o_flags_c & 8'hC5) == 8'h00 && o_flags_b[2:1] == 2'h0)
      else $error("unimplemented flag bit set");
   chk_adc_sets: assert property (i_adc_done_evt |=> o_flags_a[6])
      else $error("adc flag not set by event");
   chk_rx_mirror: assert property ($past(i_rst_n) |-> o_flags_a[5] == $past(i_serial_rx_pending))
      else $error("rx flag does not follow its source");
   chk_periph_req: assert property (o_periph_irq_req == (i_peripheral_irq_enable
      && |((o_flags_a & i_enable_a) | (o_flags_b & i_enable_b) | (o_flags_c & i_enable_c))))
      else $error("peripheral request mismatch");
   chk_read_a: assert property (i_rd_en && i_addr == 4'h0 |=> o_rd_data == $past(o_flags_a))
      else $error("read data differs from flags a");
   chk_read_idle: assert property (!i_rd_en |=> o_rd_data == 8'h00)
      else $error("read data outside read cycle");
   chk_write_clear: assert property (i_wr_en && i_addr == 4'h0 && i_wr_data == 8'h00
      && !i_adc_done_evt |=> !o_flags_a[6])
      else $error("adc flag not cleared by write");
   chk_write_set: assert property (i_wr_en && i_addr == 4'h2 && i_wr_data[5] |=> o_flags_c[5])
      else $error("capture4 flag not set by write");
   chk_reset_clear: assert property (disable iff (1'b0)
      !i_rst_n |=> (o_flags_a | o_flags_b | o_flags_c) == 8'h00)
      else $error("flags not cleared by reset");

   cov_adc: cover property (i_adc_done_evt ##1 o_flags_a[6]);
   cov_read: cover property (i_rd_en && i_addr == 4'h0);
   cov_req: cover property ($rose(o_periph_irq_req));
endmodule : pif_flags_chk

bind pif_flags pif_flags_chk u_pif_flags_chk (.*);

// file: test/tb_pif_flags.sv
// Self-checking bench for the peripheral request flag block.
module tb_pif_flags;
   timeunit 1ns;
   timeprecision 1ps;
   import pif_pkg::*;
   logic         clk, rst_n, we, re, peripheral_irq_enable, preq, irq;
   pif_addr_type addr;
   pif_byte_type wd, rdd, fa, fb, fc, en_a, en_b, en_c, fb_s;
   logic [15:0]  fire, ev;
   logic [1:0]   lvl, pend;
   int           error_cnt, checks_done, cyc;
   byte          rg[16] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2};
   byte          bt[16] = '{7, 6, 3, 2, 1, 0, 7, 6, 5, 4, 3, 0, 5, 4, 3, 1};
   pif_byte_type full[3] = '{8'hCF, 8'hF9, 8'h3A};

   pif_periph_model u_pif_periph_model (.i_core_clk(clk), .i_fire(fire), .i_level(lvl),
      .o_evt(ev), .o_pending(pend));
   pif_flags u_pif_flags (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wd),
      .i_wr_en(we), .i_rd_en(re), .o_rd_data(rdd),
      .i_timer1_gate_evt(ev[0]), .i_adc_done_evt(ev[1]), .i_serial_rx_pending(pend[0]),
      .i_serial_tx_pending(pend[1]), .i_sync_serial_evt(ev[2]), .i_capture1_evt(ev[3]),
      .i_timer2_match_evt(ev[4]), .i_timer1_overflow_evt(ev[5]), .i_osc_fail_evt(ev[6]),
      .i_comparator2_evt(ev[7]), .i_comparator1_evt(ev[8]), .i_eeprom_write_done_evt(ev[9]),
      .i_bus_collision_evt(ev[10]), .i_capture2_evt(ev[11]), .i_capture4_evt(ev[12]),
      .i_capture3_evt(ev[13]), .i_timer6_match_evt(ev[14]), .i_timer4_match_evt(ev[15]),
      .i_enable_a(en_a), .i_enable_b(en_b), .i_enable_c(en_c),
      .i_peripheral_irq_enable(peripheral_irq_enable), .o_flags_a(fa), .o_flags_b(fb), .o_flags_c(fc),
      .o_periph_irq_req(preq), .o_irq(irq));
   pif_flags #(.LARGE_VARIANT(1'b0)) u_pif_flags_small (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_addr(addr), .i_wr_data(wd), .i_wr_en(we), .i_rd_en(re), .o_rd_data(),
      .i_timer1_gate_evt(ev[0]), .i_adc_done_evt(ev[1]), .i_serial_rx_pending(pend[0]),
      .i_serial_tx_pending(pend[1]), .i_sync_serial_evt(ev[2]), .i_capture1_evt(ev[3]),
      .i_timer2_match_evt(ev[4]), .i_timer1_overflow_evt(ev[5]), .i_osc_fail_evt(ev[6]),
      .i_comparator2_evt(ev[7]), .i_comparator1_evt(ev[8]), .i_eeprom_write_done_evt(ev[9]),
      .i_bus_collision_evt(ev[10]), .i_capture2_evt(ev[11]), .i_capture4_evt(ev[12]),
      .i_capture3_evt(ev[13]), .i_timer6_match_evt(ev[14]), .i_timer4_match_evt(ev[15]),
      .i_enable_a(en_a), .i_enable_b(en_b), .i_enable_c(en_c),
      .i_peripheral_irq_enable(peripheral_irq_enable), .o_flags_a(), .o_flags_b(fb_s), .o_flags_c(),
      .o_periph_irq_req(), .o_irq());

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   task chk(string n, pif_byte_type e, pif_byte_type s);
      checks_done++;
      if (s !== e) begin
         $display("BAD %s expected %h seen %h", n, e, s);
         error_cnt++;
      end
   endtask : chk

   task wr(pif_addr_type a, pif_byte_type d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      we <= 1'b0;
      #1;
   endtask : wr

   task rd(pif_addr_type a, pif_byte_type e);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1;
      chk($sformatf("register %h", a), e, rdd);
   endtask : rd

   task pulse(int i);
      @(posedge clk);
      fire <= 16'h0001 << i;
      @(posedge clk);
      fire <= 16'h0000;
      @(posedge clk);
   endtask : pulse

   task do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset

   task t_reset_state();
      for (int r = 0; r < 5; r++) begin
         rd(4'(r), 8'h00);
      end
      rd(4'hF, 8'h00);
      chk("irq", 8'h00, irq);
   endtask : t_reset_state

   task t_sources();
      for (int i = 0; i < 16; i++) begin
         pulse(i);
         rd(4'(rg[i]), 8'h01 << bt[i]);
         chk("periph_req", 8'h00, preq);
         wr(4'(rg[i]), 8'h00);
         rd(4'(rg[i]), 8'h00);
      end
   endtask : t_sources

   task t_rxtx();
      @(posedge clk);
      lvl <= 2'b01;
      repeat (3) @(posedge clk);
      rd(4'h0, 8'h20);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h20);
      @(posedge clk);
      lvl <= 2'b10;
      repeat (3) @(posedge clk);
      rd(4'h0, 8'h10);
      @(posedge clk);
      lvl <= 2'b00;
      repeat (3) @(posedge clk);
      rd(4'h0, 8'h00);
   endtask : t_rxtx

   task t_write();
      for (int r = 0; r < 3; r++) begin
         wr(4'(r), 8'hFF);
         rd(4'(r), full[r]);
      end
      chk("flags_a", 8'hCF, fa);
      chk("flags_b", 8'hF9, fb);
      chk("flags_c", 8'h3A, fc);
      chk("flags_b small", 8'hB9, fb_s);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      do_reset();
      for (int r = 0; r < 3; r++) begin
         rd(4'(r), 8'h00);
      end
   endtask : t_write

   task t_irq();
      // The event status bits are cleared before any enable is turned on.
      wr(4'h3, 8'h07);
      rd(4'h3, 8'h00);
      @(posedge clk);
      en_a <= 8'h40;
      pulse(1);
      #1;
      chk("periph_req", 8'h00, preq);
      @(posedge clk);
      peripheral_irq_enable <= 1'b1;
      #1;
      chk("periph_req", 8'h01, preq);
      wr(4'h4, 8'h01);
      chk("irq", 8'h01, irq);
      rd(4'h3, 8'h01);
      wr(4'h4, 8'h00);
      chk("irq", 8'h00, irq);
      wr(4'h4, 8'h01);
      wr(4'h3, 8'h01);
      chk("irq", 8'h00, irq);
      wr(4'h0, 8'h00);
      chk("periph_req", 8'h00, preq);
   endtask : t_irq

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      rst_n = 1'b0;
      {we, re, peripheral_irq_enable} = 3'h0;
      addr = 4'h0;
      wd = 8'h00;
      fire = 16'h0000;
      lvl = 2'h0;
      {en_a, en_b, en_c} = 24'h000000;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_state();
      t_sources();
      t_rxtx();
      t_write();
      t_irq();
      test_done();
   end
endmodule : tb_pif_flags
